// ===== include/fcsu_cfg.svh
// Constants of the flash command and status unit: offsets, fields, codes.
// Assumes inclusion by bare name from the include folder.
`ifndef FCSU_CFG_SVH
`define FCSU_CFG_SVH
`define FCSU_ADDR_STATUS 4'h0
`define FCSU_ADDR_COMMAND 4'h1
`define FCSU_ADDR_DIVIDER 4'h2
`define FCSU_ADDR_IRQ_STATUS 4'h3
`define FCSU_ADDR_IRQ_MASK 4'h4
`define FCSU_ADDR_SECURITY 4'h5
`define FCSU_BIT_BUF_EMPTY 7
`define FCSU_BIT_COMPLETE 6
`define FCSU_BIT_PROT_VIOL 5
`define FCSU_BIT_ACC_ERR 4
`define FCSU_BIT_BLANK 2
`define FCSU_CMD_BLANK 8'h05
`define FCSU_CMD_BYTE_PROG 8'h20
`define FCSU_CMD_BURST_PROG 8'h25
`define FCSU_CMD_PAGE_ERASE 8'h40
`define FCSU_CMD_MASS_ERASE 8'h41
`define FCSU_PAGE_BYTES 512
`define FCSU_SEC_UNSECURED 2'h2
`define FCSU_SEC_RESET 2'h0
`define FCSU_DIV_RESET 8'h00
`define FCSU_CMD_RESET 8'h00
`endif

// ===== include/fcsu_pkg.sv
// Types of the flash command and status unit.
// Assumes nothing beyond a SystemVerilog compiler.
package fcsu_pkg;
    typedef enum logic [2:0] {
        FCSU_IDLE = 3'b001,
        FCSU_BUSY = 3'b010,
        FCSU_DONE = 3'b100
    } fcsu_state_type;
endpackage

// ===== verilog/fcsu_top.sv
// Command and status front end of an on-chip flash controller.
// Assumes a flash array that takes commands by start and reports done.
//
// How it works
// R01 - Status bits 3, 1 and 0 read zero; writes there do nothing.
// R02 - Buffer empty clears on write of one that queues a burst; sets again when buffered burst starts.
// R03 - Only burst programs queue; buffer empty one means room, zero full.
// R04 - Complete flag set when buffer empty and idle; clears on valid launch.
// R05 - Protected erase or program is ignored and sets protection violation.
// R06 - Access error on bad sequence, undivided clock, or stop mid command. Code lets blank check start before any divider write.
// R07 - Access error clears only by writing one; zero leaves it.
// R08 - Blank flag set after erased blank check; cleared on next valid launch. Code does not set it when a burst is queued behind the check.
// R09 - Software reads blank flag only after blank check completes.
// R10 - Code 0x41 is mass erase, 0x05 is blank check.
// R11 - Code 0x20 is byte program, 0x25 is burst program.
// R12 - Code 0x40 erases one page of 512 bytes.
// R13 - Any other code is illegal and sets access error.
// R14 - Blank check is needed only for unlocking security.
// R15 - Successful blank check sets security code to unsecured 10. Code does not set it when a burst is queued behind the check.
// R16 - Protected locations are never erased or programmed.
// R17 - Software writes address and data, then code, then launches.
// R18 - Divider written since reset is tracked to catch early commands.
`timescale 1ns/1ps
`include "fcsu_cfg.svh"
module fcsu_top (
    // Clock, reset, enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Array side, same clock domain.
    input wire logic array_data_written,
    input wire logic target_protected,
    input wire logic array_done,
    input wire logic array_blank,
    input wire logic stop_entry,
    output logic array_start,
    output logic [7:0] array_cmd,
    output logic [7:0] clock_divider,
    output logic [1:0] security_state_code,
    // Interrupt.
    output logic irq
);
    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic fcsu_legal(input logic [7:0] c);
        fcsu_legal = (c == `FCSU_CMD_BLANK) || // R10
            (c == `FCSU_CMD_MASS_ERASE) || // R10
            (c == `FCSU_CMD_BYTE_PROG) || // R11
            (c == `FCSU_CMD_BURST_PROG) || // R11
            (c == `FCSU_CMD_PAGE_ERASE); // R12
    endfunction
    function automatic logic fcsu_modifies(input logic [7:0] c);
        fcsu_modifies = (c != `FCSU_CMD_BLANK);
    endfunction

    fcsu_pkg::fcsu_state_type state_reg;
    logic buf_empty_reg;
    logic pend_reg;
    logic [7:0] pend_cmd_reg;
    logic complete_reg;
    logic prot_viol_reg;
    logic acc_err_reg;
    logic blank_reg;
    logic div_written_reg;
    logic cmd_written_reg;
    logic data_written_reg;
    logic [7:0] cmd_reg;
    logic [7:0] exec_cmd_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;

    // ****************************************
    // Launch decode
    // ****************************************
    logic wr_status;
    logic wr_cmd;
    logic launch;
    logic launch_bad;
    logic launch_prot;
    logic launch_ok;
    logic busy;
    logic handoff;
    logic accept_err;
    logic done_evt;
    assign wr_status = reg_wr && reg_addr == `FCSU_ADDR_STATUS;
    assign wr_cmd = reg_wr && reg_addr == `FCSU_ADDR_COMMAND;
    assign busy = state_reg == fcsu_pkg::FCSU_BUSY;
    assign launch = wr_status && reg_wdata[`FCSU_BIT_BUF_EMPTY]
        && buf_empty_reg; // R02
    // Sequence: data then code; only bursts may queue behind a busy array.
    assign launch_bad = !cmd_written_reg || !data_written_reg
        || !fcsu_legal(cmd_reg)
        || (busy && cmd_reg != `FCSU_CMD_BURST_PROG) // R03
        || (fcsu_modifies(cmd_reg) && !div_written_reg); // R06 R13 R17 R18
    assign launch_prot = !launch_bad && fcsu_modifies(cmd_reg)
        && target_protected; // R05 R16
    assign launch_ok = launch && !launch_bad && !launch_prot;
    assign accept_err = launch && launch_bad;
    assign handoff = busy && array_done && pend_reg;
    assign done_evt = busy && array_done && !pend_reg;

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= fcsu_pkg::FCSU_IDLE;
            array_start <= 1'b0;
            exec_cmd_reg <= `FCSU_CMD_RESET;
            pend_reg <= 1'b0;
            pend_cmd_reg <= `FCSU_CMD_RESET;
        end else if (clk_en) begin
            array_start <= 1'b0;
            case (state_reg)
                fcsu_pkg::FCSU_IDLE: begin
                    if (launch_ok) begin
                        exec_cmd_reg <= cmd_reg;
                        array_start <= 1'b1;
                        state_reg <= fcsu_pkg::FCSU_BUSY;
                    end
                end
                fcsu_pkg::FCSU_BUSY: begin
                    if (stop_entry) begin
                        pend_reg <= 1'b0;
                        state_reg <= fcsu_pkg::FCSU_DONE; // R06
                    end else if (handoff) begin
                        exec_cmd_reg <= pend_cmd_reg; // R02
                        array_start <= 1'b1;
                        pend_reg <= 1'b0;
                    end else if (array_done && launch_ok) begin
                        // A burst launched as the array finishes goes
                        // straight on, so it is neither lost nor stuck.
                        exec_cmd_reg <= cmd_reg; // R03
                        array_start <= 1'b1;
                    end else if (array_done) begin
                        state_reg <= fcsu_pkg::FCSU_DONE;
                    end else if (launch_ok) begin
                        pend_cmd_reg <= cmd_reg; // R03
                        pend_reg <= 1'b1;
                    end
                end
                fcsu_pkg::FCSU_DONE: begin
                    if (launch_ok) begin
                        exec_cmd_reg <= cmd_reg;
                        array_start <= 1'b1;
                        state_reg <= fcsu_pkg::FCSU_BUSY;
                    end else begin
                        state_reg <= fcsu_pkg::FCSU_IDLE;
                    end
                end
                default: begin
                    state_reg <= fcsu_pkg::FCSU_IDLE;
                end
            endcase
        end
    end
    assign array_cmd = exec_cmd_reg;

    // ****************************************
    // Command sequence tracking
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmd_reg <= `FCSU_CMD_RESET;
            cmd_written_reg <= 1'b0;
            data_written_reg <= 1'b0;
        end else if (clk_en) begin
            if (launch) begin
                cmd_written_reg <= 1'b0;
                data_written_reg <= 1'b0;
            end else if (wr_cmd) begin
                cmd_reg <= reg_wdata;
                cmd_written_reg <= data_written_reg; // R17
            end else if (array_data_written) begin
                data_written_reg <= 1'b1;
                cmd_written_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            buf_empty_reg <= 1'b1;
        end else if (clk_en) begin
            // Only a burst queued behind a running command fills the buffer.
            if (launch_ok && busy && !array_done && !stop_entry) begin
                buf_empty_reg <= 1'b0; // R03
            end else if (launch || handoff || stop_entry) begin
                buf_empty_reg <= 1'b1; // R02
            end
        end
    end
    // A valid launch clears the flag; the bursting array keeps it low.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            complete_reg <= 1'b1;
        end else if (clk_en) begin
            if (launch_ok) begin
                complete_reg <= 1'b0; // R04
            end else begin
                complete_reg <= buf_empty_reg && !pend_reg
                    && state_reg != fcsu_pkg::FCSU_BUSY; // R04
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prot_viol_reg <= 1'b0;
            acc_err_reg <= 1'b0;
        end else if (clk_en) begin
            if (launch && launch_prot) begin
                prot_viol_reg <= 1'b1; // R05
            end else if (wr_status && reg_wdata[`FCSU_BIT_PROT_VIOL]) begin
                prot_viol_reg <= 1'b0;
            end
            if (accept_err || (busy && stop_entry)) begin
                acc_err_reg <= 1'b1; // R06 R13
            end else if (wr_status && reg_wdata[`FCSU_BIT_ACC_ERR]) begin
                acc_err_reg <= 1'b0; // R07
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            blank_reg <= 1'b0;
            security_state_code <= `FCSU_SEC_RESET;
        end else if (clk_en) begin
            if (done_evt && exec_cmd_reg == `FCSU_CMD_BLANK && array_blank
                && !stop_entry) begin
                blank_reg <= 1'b1; // R08
                security_state_code <= `FCSU_SEC_UNSECURED; // R15
            end else if (launch_ok) begin
                blank_reg <= 1'b0; // R08
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clock_divider <= `FCSU_DIV_RESET;
            div_written_reg <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `FCSU_ADDR_DIVIDER) begin
                clock_divider <= reg_wdata;
                div_written_reg <= 1'b1; // R18
            end
        end
    end

    // ****************************************
    // Interrupts: bit 0 command done, bit 1 error
    // ****************************************
    logic [1:0] irq_evt;
    assign irq_evt = {accept_err || launch_prot || (busy && stop_entry),
        done_evt};
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `FCSU_ADDR_IRQ_STATUS) begin
                irq_stat_reg <= (irq_stat_reg & ~reg_wdata[1:0]) | irq_evt;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_evt;
            end
            if (reg_wr && reg_addr == `FCSU_ADDR_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[1:0];
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `FCSU_ADDR_STATUS: reg_rdata <= {buf_empty_reg,
                        complete_reg, prot_viol_reg, acc_err_reg, 1'b0,
                        blank_reg, 2'b00}; // R01
                    `FCSU_ADDR_COMMAND: reg_rdata <= cmd_reg;
                    `FCSU_ADDR_DIVIDER: reg_rdata <= clock_divider;
                    `FCSU_ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_stat_reg};
                    `FCSU_ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
                    `FCSU_ADDR_SECURITY:
                        reg_rdata <= {6'h00, security_state_code};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // fcsu_top

// ===== testbench/fcsu_monitor.sv
// Checker of the flash command unit, watching its ports only.
// Assumes one clock domain and the indexes of the cfg header.
`timescale 1ns/1ps
`include "fcsu_cfg.svh"
module fcsu_monitor (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Array side.
    input wire logic target_protected,
    input wire logic array_done,
    input wire logic array_blank,
    input wire logic array_start,
    input wire logic [7:0] array_cmd,
    input wire logic [7:0] clock_divider,
    input wire logic [1:0] security_state_code
);
    logic div_seen_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst)
            div_seen_reg <= 1'b0;
        else if (reg_wr && reg_addr == `FCSU_ADDR_DIVIDER)
            div_seen_reg <= 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence blank_pass;
        array_done && array_blank && array_cmd == `FCSU_CMD_BLANK;
    endsequence
    sequence status_read;
        reg_rd && reg_addr == `FCSU_ADDR_STATUS;
    endsequence
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_status_rsvd_zero: assert property (status_read |=>
        reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0)
        else $error("reserved status bits set");
    a_start_one_pulse: assert property (array_start |=> !array_start)
        else $error("start longer than a pulse");
    a_start_code_legal: assert property (
        array_start |-> array_cmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
        else $error("illegal code started");
    a_start_unprotected: assert property (
        array_start |-> !$past(target_protected))
        else $error("protected target started");
    a_start_after_div: assert property (array_start |-> div_seen_reg)
        else $error("start before divider write");
    a_div_write_lands: assert property (
        reg_wr && reg_addr == `FCSU_ADDR_DIVIDER
        |=> clock_divider == $past(reg_wdata))
        else $error("divider not written");
    a_sec_only_unlock: assert property ($changed(security_state_code)
        |-> security_state_code == `FCSU_SEC_UNSECURED)
        else $error("security code changed wrongly");
    a_blank_unlocks: assert property (blank_pass |=> ##[0:3]
        security_state_code == `FCSU_SEC_UNSECURED)
        else $error("blank pass did not unlock");
endmodule // fcsu_monitor
bind fcsu_top fcsu_monitor u_mon (.mclk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .target_protected, .array_done,
    .array_blank, .array_start, .array_cmd, .clock_divider,
    .security_state_code);

// ===== testbench/fcsu_array_model.sv
// Behavioural flash array answering each start with one done pulse.
// Assumes one operation at a time.
`timescale 1ns/1ps
module fcsu_array_model #(
    parameter int DONE_DELAY = 20
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Command side.
    input wire logic array_start,
    input wire logic blank_val,
    output logic array_done,
    output logic array_blank
);
    int count_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_reg <= 0;
            array_done <= 1'b0;
        end else begin
            array_done <= (count_reg == 1);
            if (array_start)
                count_reg <= DONE_DELAY;
            else if (count_reg > 0)
                count_reg <= count_reg - 1;
        end
    end
    // Outside the done pulse the result is not valid, so it is inverted.
    assign array_blank = array_done ? blank_val : ~blank_val;
endmodule // fcsu_array_model

// ===== testbench/testbench.sv
// Self-checking bench of the flash command unit.
// Assumes the cfg header, the array model and the checker.
`timescale 1ns/1ps
`include "fcsu_cfg.svh"
module testbench;
    logic mclk, sys_rst, reg_wr, reg_rd, array_data_written, stop_entry;
    logic target_protected, array_done, array_blank, array_start;
    logic blank_val, irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, array_cmd, clock_divider, v, last_cmd;
    logic [1:0] security_state_code;
    int miscompares = 0, tests_run = 0, starts = 0, n;
    fcsu_top dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .array_data_written(array_data_written),
        .target_protected(target_protected), .array_done(array_done),
        .array_blank(array_blank), .stop_entry(stop_entry),
        .array_start(array_start), .array_cmd(array_cmd),
        .clock_divider(clock_divider),
        .security_state_code(security_state_code), .irq(irq));
    fcsu_array_model #(.DONE_DELAY(20)) u_array (.mclk(mclk),
        .sys_rst(sys_rst), .array_start(array_start),
        .blank_val(blank_val), .array_done(array_done),
        .array_blank(array_blank));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (array_start === 1'b1) begin
            starts++;
            last_cmd = array_cmd;
        end
    end
    task automatic chk(input string s, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic launch(input logic [7:0] c);
        @(posedge mclk);
        array_data_written <= 1'b1;
        @(posedge mclk);
        array_data_written <= 1'b0;
        wr(`FCSU_ADDR_COMMAND, c);
        wr(`FCSU_ADDR_STATUS, 8'h80);
    endtask
    task automatic settle();
        for (int i = 0; i < 100; i++) begin
            rd(`FCSU_ADDR_STATUS);
            if (v[6] === 1'b1)
                break;
        end
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`FCSU_ADDR_STATUS);
        chk("status", 8'hC0, v);
        wr(`FCSU_ADDR_STATUS, 8'h0B);
        rd(`FCSU_ADDR_STATUS);
        chk("status", 8'hC0, v);
        rd(4'hF);
        chk("unmapped", 8'h00, v);
        chk("security", 8'h00, {6'h00, security_state_code});
    endtask
    task automatic t_err();
        n = starts;
        launch(8'h20);
        settle();
        chk("status", 8'hD0, v);
        wr(`FCSU_ADDR_STATUS, 8'h00);
        rd(`FCSU_ADDR_STATUS);
        chk("status", 8'hD0, v);
        wr(`FCSU_ADDR_STATUS, 8'h10);
        wr(`FCSU_ADDR_DIVIDER, 8'h13);
        rd(`FCSU_ADDR_STATUS);
        chk("status", 8'hC0, v);
        chk("divider", 8'h13, clock_divider);
        launch(8'h33);
        settle();
        chk("status", 8'hD0, v);
        wr(`FCSU_ADDR_STATUS, 8'h10);
        target_protected <= 1'b1;
        launch(8'h40);
        settle();
        chk("status", 8'hE0, v);
        wr(`FCSU_ADDR_STATUS, 8'h20);
        target_protected <= 1'b0;
        chk("starts", 8'h00, 8'(starts - n));
        launch(8'h20);
        stop_entry <= 1'b1;
        @(posedge mclk);
        stop_entry <= 1'b0;
        settle();
        chk("stop error", 8'h10, v & 8'h10);
        wr(`FCSU_ADDR_STATUS, 8'h10);
    endtask
    task automatic t_codes();
        logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
        for (int i = 0; i < 6; i++) begin
            blank_val <= (i == 5);
            n = starts;
            launch(codes[i]);
            settle();
            chk("starts", 8'h01, 8'(starts - n));
            chk("cmd", codes[i], last_cmd);
            chk("status", (i == 5) ? 8'hC4 : 8'hC0, v);
            rd(`FCSU_ADDR_SECURITY);
            chk("security", (i == 5) ? 8'h02 : 8'h00, v);
        end
        chk("security", 8'h02, {6'h00, security_state_code});
        blank_val <= 1'b0;
        launch(8'h20);
        settle();
        chk("status", 8'hC0, v);
        rd(`FCSU_ADDR_COMMAND);
        chk("command", 8'h20, v);
    endtask
    task automatic t_burst();
        n = starts;
        launch(8'h25);
        launch(8'h25);
        rd(`FCSU_ADDR_STATUS);
        chk("status", 8'h00, v);
        settle();
        chk("starts", 8'h02, 8'(starts - n));
        chk("status", 8'hC0, v);
    endtask
    task automatic t_irq();
        rd(`FCSU_ADDR_IRQ_STATUS);
        chk("irq status", 8'h01, v & 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        wr(`FCSU_ADDR_IRQ_MASK, 8'h01);
        rd(`FCSU_ADDR_IRQ_MASK);
        chk("irq mask", 8'h01, v);
        repeat (2) @(posedge mclk);
        chk("irq", 8'h01, {7'h00, irq});
        wr(`FCSU_ADDR_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge mclk);
        chk("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // The tests take about 400 cycles; the watchdog allows 30000 cycles, some seventy times that.
    initial begin
        #300000;
        miscompares++;
        end_sim();
    end
    initial begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        array_data_written = 1'b0;
        target_protected = 1'b0;
        stop_entry = 1'b0;
        blank_val = 1'b0;
        do_reset();
        t_err();
        t_codes();
        t_burst();
        t_irq();
        do_reset();
        end_sim();
    end
endmodule // testbench
